/* File: rtl/epcm_top.sv */
// Eccentric press contact monitor: checks cam edge order and stopping
// overrun, drives permit, dead-centre and rising-stroke phase outputs.
// Assumes asynchronous field pins and a plain register port on core_clk.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Stop-zone cam rising while rising-stroke cam low is a sequence fault.
// - Stop-zone cam falling while rising-stroke cam high is a sequence fault.
// - Rising-stroke cam rising while stop-zone cam high is a sequence fault.
// - Rising-stroke cam falling while stop-zone cam low is a sequence fault.
// - Any sequence fault drops permit and raises the sequence-fault output.
// - Drive feedback must rise at dead centre or be high at stop-zone fall.
// - Bypass without fault holds permit low, suspends checks, keeps fault outputs.
// - Bypass with a latched fault still accepts an acknowledge.
// - Bypass falling without fault restarts supervision and returns permit high.
// - Permit high without fault; fault drops it and raises acknowledge-needed.
// - Acknowledge is a high pulse between configured minimum and 30 s.
// - Without early cam, phase set on rising-stroke rise, cleared on stop-zone rise.
// - With early cam, dead centre starts on first of stop-zone rise, early fall.
module epcm_top #(
    parameter logic [31:0] ACK_MIN_SHORT = epcm_pkg::ACK_MIN_SHORT_CYC,
    parameter logic [31:0] ACK_MIN_LONG  = epcm_pkg::ACK_MIN_LONG_CYC,
    parameter logic [31:0] ACK_MAX       = epcm_pkg::ACK_MAX_CYC
) (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire epcm_pkg::epcm_in_t     cam_pins,
    input  wire logic [3:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    output var epcm_pkg::epcm_out_t     press,
    output logic                        irq
);

    // Edge helpers shared by every contact
    function automatic logic rise(input logic cur, input logic prv);
        rise = cur & ~prv;
    endfunction

    function automatic logic fall(input logic cur, input logic prv);
        fall = ~cur & prv;
    endfunction

    epcm_pkg::epcm_in_t  s1_r;
    epcm_pkg::epcm_in_t  smp_r;
    epcm_pkg::epcm_in_t  prv_r;

    logic [1:0]          init_cnt_r;
    logic [1:0]          init_cnt_nxt;
    logic                contact_err_r;
    logic                contact_err_nxt;
    logic                overrun_err_r;
    logic                overrun_err_nxt;
    logic                top_r;
    logic                top_nxt;
    logic                up_r;
    logic                up_nxt;
    logic                drv_ok_r;
    logic                drv_ok_nxt;
    logic                early_r;
    logic                early_nxt;
    logic                permit_r;
    logic                permit_nxt;
    logic [31:0]         ack_cnt_r;
    logic [31:0]         ack_cnt_nxt;

    logic [1:0]          ctrl_r;
    logic [1:0]          ctrl_nxt;
    logic [2:0]          int_stat_r;
    logic [2:0]          int_stat_nxt;
    logic [2:0]          int_mask_r;
    logic [2:0]          int_mask_nxt;
    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;

    logic                init;
    logic                fault;
    logic                active;
    logic                r_ov;
    logic                f_ov;
    logic                r_up;
    logic                f_up;
    logic                f_dyn;
    logic                r_drv;
    logic                f_ack;
    logic                f_byp;
    logic                seq_bad;
    logic                ovr_bad;
    logic                ack_ok;
    logic                ack_clear;
    logic [31:0]         ack_min;
    logic [2:0]          events;

    // Two-stage synchroniser, then one stage of history for edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r  <= '0;
            smp_r <= '0;
            prv_r <= '0;
        end else begin
            s1_r  <= cam_pins;
            smp_r <= s1_r;
            prv_r <= smp_r;
        end
    end

    // Edge and check terms of the current logic cycle
    always_comb begin
        init    = (init_cnt_r != epcm_pkg::SYNC_FILL);
        fault   = contact_err_r | overrun_err_r;
        // Checks idle during start-up, fault and bypass
        active  = !init && !fault && !smp_r.bypass;
        r_ov    = rise(smp_r.overrun, prv_r.overrun);
        f_ov    = fall(smp_r.overrun, prv_r.overrun);
        r_up    = rise(smp_r.upstroke, prv_r.upstroke);
        f_up    = fall(smp_r.upstroke, prv_r.upstroke);
        f_dyn   = fall(smp_r.dyncam, prv_r.dyncam);
        r_drv   = rise(smp_r.drive, prv_r.drive);
        f_ack   = fall(smp_r.ack, prv_r.ack);
        f_byp   = fall(smp_r.bypass, prv_r.bypass);
        seq_bad = active && ((r_ov && !smp_r.upstroke)
                          || (f_ov && smp_r.upstroke)
                          || (r_up && smp_r.overrun)
                          || (f_up && !smp_r.overrun));
        // Drive feedback judges motion; it must mirror the drive command
        ovr_bad = active && f_ov && !smp_r.drive && !drv_ok_r;
        ack_min = ctrl_r[epcm_pkg::CTRL_LONG_BIT] ? ACK_MIN_LONG : ACK_MIN_SHORT;
        ack_ok  = f_ack && (ack_cnt_r >= ack_min) && (ack_cnt_r <= ACK_MAX);
        // Accepted in bypass as well
        ack_clear = fault && ack_ok;
        events  = 3'h0;
        events[epcm_pkg::INT_SEQ_BIT] = seq_bad;
        events[epcm_pkg::INT_OVR_BIT] = ovr_bad;
        events[epcm_pkg::INT_ACK_BIT] = ack_clear;
    end

    // Next supervision state
    always_comb begin
        init_cnt_nxt    = init ? init_cnt_r + 2'h1 : init_cnt_r;
        contact_err_nxt = contact_err_r | seq_bad;
        overrun_err_nxt = overrun_err_r | ovr_bad;
        top_nxt         = top_r;
        up_nxt          = up_r;
        drv_ok_nxt      = drv_ok_r;
        early_nxt       = early_r;

        // Saturate one past the limit so long pulses stay rejected
        if (smp_r.ack) begin
            ack_cnt_nxt = (ack_cnt_r > ACK_MAX) ? ack_cnt_r : ack_cnt_r + 32'h1;
        end else begin
            ack_cnt_nxt = 32'h0;
        end

        // A valid acknowledge clears faults and reinitialises
        if (ack_clear) begin
            contact_err_nxt = 1'b0;
            overrun_err_nxt = 1'b0;
            init_cnt_nxt    = epcm_pkg::SYNC_FILL - 2'h1;
        end else if (f_byp && !fault) begin
            init_cnt_nxt    = epcm_pkg::SYNC_FILL - 2'h1;
        end

        if (fault || smp_r.bypass) begin
            top_nxt    = 1'b0;
            up_nxt     = 1'b0;
            drv_ok_nxt = 1'b0;
            early_nxt  = 1'b0;
        end else if (init) begin
            // History is loaded now, so a cam already high makes no edge
            top_nxt    = smp_r.overrun;
            up_nxt     = 1'b0;
            drv_ok_nxt = 1'b0;
            early_nxt  = 1'b0;
        end else begin
            if (f_ov) begin
                drv_ok_nxt = 1'b0;
            end else if (r_drv && top_r) begin
                drv_ok_nxt = 1'b1;
            end
            if (!ctrl_r[epcm_pkg::CTRL_DYN_BIT]) begin
                top_nxt = smp_r.overrun;
                if (r_up) begin
                    up_nxt = 1'b1;
                end
                if (r_ov) begin
                    up_nxt = 1'b0;
                end
                early_nxt = 1'b0;
            end else begin
                // Early cam in the downstroke blocks the coming upstroke
                if (r_up && !early_r) begin
                    up_nxt = 1'b1;
                end
                if (r_ov || f_dyn) begin
                    up_nxt  = 1'b0;
                    top_nxt = 1'b1;
                end
                if (f_ov || (r_up && early_r)) begin
                    top_nxt = 1'b0;
                end
                if (f_dyn && !smp_r.upstroke) begin
                    early_nxt = 1'b1;
                end else if (r_ov) begin
                    early_nxt = 1'b0;
                end
            end
            if (seq_bad || ovr_bad) begin
                top_nxt = 1'b0;
                up_nxt  = 1'b0;
            end
        end

        permit_nxt = !(contact_err_nxt || overrun_err_nxt)
                  && !smp_r.bypass
                  && (init_cnt_nxt == epcm_pkg::SYNC_FILL);
    end

    // Supervision registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_cnt_r    <= 2'h0;
            contact_err_r <= 1'b0;
            overrun_err_r <= 1'b0;
            top_r         <= 1'b0;
            up_r          <= 1'b0;
            drv_ok_r      <= 1'b0;
            early_r       <= 1'b0;
            permit_r      <= 1'b0;
            ack_cnt_r     <= 32'h0;
        end else begin
            init_cnt_r    <= init_cnt_nxt;
            contact_err_r <= contact_err_nxt;
            overrun_err_r <= overrun_err_nxt;
            top_r         <= top_nxt;
            up_r          <= up_nxt;
            drv_ok_r      <= drv_ok_nxt;
            early_r       <= early_nxt;
            permit_r      <= permit_nxt;
            ack_cnt_r     <= ack_cnt_nxt;
        end
    end

    // Register port: writes, interrupt status and the registered read
    always_comb begin
        ctrl_nxt     = ctrl_r;
        int_mask_nxt = int_mask_r;
        int_stat_nxt = int_stat_r;
        rdata_nxt    = 32'h0;
        if (reg_wr && reg_addr == epcm_pkg::REG_CTRL) begin
            ctrl_nxt = reg_wdata[epcm_pkg::CTRL_W-1:0];
        end
        if (reg_wr && reg_addr == epcm_pkg::REG_INT_MASK) begin
            int_mask_nxt = reg_wdata[epcm_pkg::INT_W-1:0];
        end
        // Clear by writing one; a same-cycle event wins
        if (reg_wr && reg_addr == epcm_pkg::REG_INT_STAT) begin
            int_stat_nxt = int_stat_r & ~reg_wdata[epcm_pkg::INT_W-1:0];
        end
        int_stat_nxt = int_stat_nxt | events;
        if (reg_rd) begin
            case (reg_addr)
                epcm_pkg::REG_CTRL: begin
                    rdata_nxt[epcm_pkg::CTRL_W-1:0] = ctrl_r;
                end
                epcm_pkg::REG_STATUS: begin
                    rdata_nxt[epcm_pkg::STAT_OUT_W-1:0] = press;
                    rdata_nxt[epcm_pkg::STAT_BYPASS_BIT] = smp_r.bypass;
                end
                epcm_pkg::REG_INT_STAT: begin
                    rdata_nxt[epcm_pkg::INT_W-1:0] = int_stat_r;
                end
                epcm_pkg::REG_INT_MASK: begin
                    rdata_nxt[epcm_pkg::INT_W-1:0] = int_mask_r;
                end
                default: begin
                    rdata_nxt = 32'h0;
                end
            endcase
        end
    end

    // Register-port flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r     <= epcm_pkg::CTRL_RST;
            int_stat_r <= epcm_pkg::INT_RST;
            int_mask_r <= epcm_pkg::INT_RST;
            rdata_r    <= 32'h0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // Outputs from flops; ack_need is the OR of the two fault flops
    always_comb begin
        press.permit      = permit_r;
        press.top         = top_r;
        press.upstroke    = up_r;
        press.ack_need    = contact_err_r | overrun_err_r;
        press.contact_err = contact_err_r;
        press.overrun_err = overrun_err_r;
    end

    assign reg_rdata = rdata_r;
    assign irq       = |(int_stat_r & int_mask_r);

endmodule // epcm_top

`default_nettype wire

/* File: rtl/epcm_pkg.sv */
// Package for the eccentric press contact monitor: timing counts,
// register map, field positions and the pin and output carriers.
// Assumes a single 125 MHz core clock.
package epcm_pkg;

    // Core clock rate and the acknowledge pulse limits in their own units
    localparam longint unsigned CLK_HZ           = 64'd125000000;
    localparam longint unsigned MS_PER_S         = 64'd1000;
    localparam longint unsigned ACK_MIN_SHORT_MS = 64'd100;
    localparam longint unsigned ACK_MIN_LONG_MS  = 64'd350;
    localparam longint unsigned ACK_MAX_MS       = 64'd30000;

    // Least times round up, the longest time rounds down
    localparam logic [31:0] ACK_MIN_SHORT_CYC =
        32'((ACK_MIN_SHORT_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
    localparam logic [31:0] ACK_MIN_LONG_CYC  =
        32'((ACK_MIN_LONG_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
    localparam logic [31:0] ACK_MAX_CYC       = 32'((ACK_MAX_MS * CLK_HZ) / MS_PER_S);

    // Cycles until the pin synchronisers hold real samples after reset
    localparam logic [1:0] SYNC_FILL = 2'h3;

    // Register map, byte addresses
    localparam int          REG_AW       = 4;
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_INT_STAT = 4'h8;
    localparam logic [3:0]  REG_INT_MASK = 4'hc;

    // Control fields
    localparam int          CTRL_W        = 2;
    localparam int          CTRL_DYN_BIT  = 0;
    localparam int          CTRL_LONG_BIT = 1;
    localparam logic [1:0]  CTRL_RST      = 2'h0;

    // Status: low bits hold the output carrier, then the bypass level
    localparam int          STAT_OUT_W      = 6;
    localparam int          STAT_BYPASS_BIT = 6;

    // Interrupt events
    localparam int          INT_W        = 3;
    localparam int          INT_SEQ_BIT  = 0;
    localparam int          INT_OVR_BIT  = 1;
    localparam int          INT_ACK_BIT  = 2;
    localparam logic [2:0]  INT_RST      = 3'h0;

    // Field inputs from cams, drive feedback, acknowledge and bypass
    typedef struct packed {
        logic bypass;
        logic ack;
        logic drive;
        logic dyncam;
        logic upstroke;
        logic overrun;
    } epcm_in_t;

    // Outputs towards the press cycle control
    typedef struct packed {
        logic overrun_err;
        logic contact_err;
        logic ack_need;
        logic upstroke;
        logic top;
        logic permit;
    } epcm_out_t;

endpackage

/* File: tb/epcm_cam_model.sv */
// Cam switch and drive feedback model for the press contact monitor.
// Assumes the bench pulses adv or bad for one cycle after an edge.
`timescale 1ns/1ps
`default_nettype none
module epcm_cam_model (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        adv,
    input  wire logic        bad,
    input  wire logic        drv_en,
    input  wire logic        dyn,
    input  wire logic        ack,
    input  wire logic        byp,
    input  wire logic        permit,
    output var epcm_pkg::epcm_in_t pins
);
    logic       ov_r;
    logic       up_r;
    logic [1:0] ph_r;
    // Legal order: stop-zone fall, rise cam rise, stop-zone rise, rise cam fall
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ov_r <= 1'b1;
            up_r <= 1'b0;
            ph_r <= 2'h0;
        end else if (adv) begin
            ov_r <= (ph_r == 2'h0) ? 1'b0 : (ph_r == 2'h2) ? 1'b1 : ov_r;
            up_r <= (ph_r == 2'h1) ? 1'b1 : (ph_r == 2'h3) ? 1'b0 : up_r;
            ph_r <= ph_r + 2'h1;
        end else if (bad) begin
            up_r <= ~up_r; // Out of order on purpose
        end
    end
    // Drive loops back from permit; drv_en low fakes a drive never released
    assign pins = {byp, ack, permit & drv_en, dyn, up_r, ov_r};
endmodule // epcm_cam_model
`default_nettype wire

/* File: tb/epcm_top_chk.sv */
// Assertions on the press outputs against the pins, and on the idle read data.
// Assumes pin changes reach the outputs two to four edges later.
`timescale 1ns/1ps
`default_nettype none
module epcm_top_chk (
    input wire logic                core_clk,
    input wire logic                arst_n,
    input wire epcm_pkg::epcm_in_t  cam_pins,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata,
    input wire epcm_pkg::epcm_out_t press
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic flt;
    // Either fault latched
    assign flt = press.contact_err | press.overrun_err;
    logic dyn_blk_r;
    // Early cam fall in the downstroke may block the coming rising phase
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dyn_blk_r <= 1'b0;
        end else if ($fell(cam_pins.dyncam) && !cam_pins.upstroke) begin
            dyn_blk_r <= 1'b1;
        end else if ($rose(cam_pins.overrun)) begin
            dyn_blk_r <= 1'b0;
        end
    end
    // Steps of an illegal edge and of a too short acknowledge
    sequence s_up_bad;
        $rose(cam_pins.upstroke) && cam_pins.overrun && press.permit && !cam_pins.bypass;
    endsequence
    sequence s_short_ack;
        press.ack_need && !cam_pins.ack ##1 cam_pins.ack ##1 !cam_pins.ack;
    endsequence
    a_fault_perm: assert property (flt |-> !press.permit && press.ack_need)
        else $error("permit high while faulted");
    a_fault_phase: assert property (flt |-> !press.top && !press.upstroke)
        else $error("phase output high while faulted");
    a_seq_order: assert property (s_up_bad |-> ##[2:4] press.contact_err)
        else $error("illegal rise cam edge missed");
    a_up_set: assert property ($rose(cam_pins.upstroke) && !cam_pins.overrun && press.permit
        && !cam_pins.bypass && !dyn_blk_r |-> ##[2:4] press.upstroke)
        else $error("rising phase not set");
    a_up_clr: assert property ($rose(cam_pins.overrun) && press.permit |-> ##[2:4] !press.upstroke)
        else $error("rising phase not cleared");
    a_top_clr: assert property ($fell(cam_pins.overrun) && press.permit |-> ##[2:4] !press.top)
        else $error("dead centre not cleared");
    a_short_ack: assert property (s_short_ack |=> press.ack_need [*6])
        else $error("short acknowledge accepted");
    a_byp_perm: assert property (cam_pins.bypass [*5] |-> !press.permit)
        else $error("permit high in bypass");
    a_byp_keep: assert property (cam_pins.bypass [*6] ##0 !flt |=> !flt)
        else $error("fault raised in bypass");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule // epcm_top_chk
bind epcm_top epcm_top_chk u_chk (.core_clk, .arst_n, .cam_pins, .reg_rd, .reg_rdata, .press);
`default_nettype wire

/* File: tb/tb_eccentric_press_contact_monitor.sv */
// Self-checking bench for the press contact monitor with a cam model.
// Assumes acknowledge limits shortened to 4, 8 and 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_eccentric_press_contact_monitor;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        adv = 1'b0, bad = 1'b0, drv_en = 1'b1, dyn = 1'b1, ack = 1'b0, byp = 1'b0;
    logic [31:0] rng = 32'hf826;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          lens [7] = '{1, 3, 4, 20, 21, 0, 0};
    epcm_pkg::epcm_in_t  cam_pins;
    epcm_pkg::epcm_out_t press;

    epcm_top #(.ACK_MIN_SHORT(32'h4), .ACK_MIN_LONG(32'h8), .ACK_MAX(32'h14)) uut (
        .core_clk(core_clk), .arst_n(arst_n), .cam_pins(cam_pins), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .press(press), .irq(irq));
    epcm_cam_model u_cam (
        .core_clk(core_clk), .arst_n(arst_n), .adv(adv), .bad(bad), .drv_en(drv_en), .dyn(dyn),
        .ack(ack), .byp(byp), .permit(press.permit), .pins(cam_pins));

    // 125 MHz clock
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard, far above the six hundred or so cycles needed
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Permit, top and rising phase per cam phase
    function automatic logic [5:0] ph_exp(input logic [1:0] ph);
        return (ph == 2'h2) ? 6'h05 : (ph == 2'h1) ? 6'h01 : 6'h03;
    endfunction
    function automatic logic ack_ok(input int n, input logic lng);
        return (n >= (lng ? 8 : 4)) && (n <= 20);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        tick(1);
    endtask
    // One cam move, legal or not, then time to reach the outputs
    task automatic step(input logic b);
        adv <= !b;
        bad <= b;
        tick(1);
        adv <= 1'b0;
        bad <= 1'b0;
        tick(6);
    endtask
    task automatic pulse(input int n);
        ack <= 1'b1;
        tick(n);
        ack <= 1'b0;
        tick(8);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(2);
        arst_n <= 1'b1;
        tick(8);
        chk(press, 6'h03);
        rd(4'h0, 32'h0);
        rd(4'hc, 32'h0);
        rd(4'h2, 32'h0);
        rd(4'h4, 32'h3);
        wr(4'hc, 32'h7);
        for (int i = 1; i <= 4; i++) begin
            step(1'b0);
            chk(press, ph_exp(2'(i)));
        end
        // Early cam cuts the rising phase short
        wr(4'h0, 32'h1);
        step(1'b0);
        step(1'b0);
        dyn <= 1'b0;
        tick(6);
        chk(press, 6'h03);
        step(1'b0);
        step(1'b0);
        // Early cam in the downstroke holds dead centre and blocks the rise
        dyn <= 1'b1;
        step(1'b0);
        dyn <= 1'b0;
        tick(6);
        chk(press, 6'h03);
        step(1'b0);
        chk(press, 6'h01);
        step(1'b0);
        chk(press, 6'h03);
        step(1'b0);
        wr(4'h0, 32'h0);
        dyn <= 1'b1;
        // Faults cleared by pulses of corner and random length
        for (int k = 0; k < 7; k++) begin
            if (k > 4) begin
                rng = xs(rng);
                lens[k] = 1 + int'(rng % 32'd24);
            end
            step(1'b1);
            chk(press, 6'h18);
            chk(irq, 1'b1);
            pulse(lens[k]);
            chk(press.ack_need, !ack_ok(lens[k], 1'b0));
            if (press.ack_need === 1'b1) begin
                pulse(10);
            end
            chk(press, 6'h03);
            step(1'b1);
        end
        rd(4'h8, 32'h5);
        wr(4'h8, 32'h7);
        chk(irq, 1'b0);
        rd(4'h8, 32'h0);
        // Long minimum, sequence event masked off
        wr(4'hc, 32'h2);
        wr(4'h0, 32'h2);
        step(1'b1);
        chk(irq, 1'b0);
        pulse(6);
        chk(press.ack_need, !ack_ok(6, 1'b1));
        pulse(8);
        chk(press.ack_need, !ack_ok(8, 1'b1));
        rd(4'h8, 32'h5);
        step(1'b1);
        wr(4'h0, 32'h0);
        // Bypass takes an acknowledge, ignores a stuck drive, restarts on release
        step(1'b1);
        byp <= 1'b1;
        pulse(10);
        chk(press, 6'h00);
        step(1'b1);
        step(1'b0);
        chk(press, 6'h00);
        rd(4'h4, 32'h40);
        byp <= 1'b0;
        tick(8);
        chk(press, 6'h01);
        // Stop-zone opens with the drive never released
        step(1'b0);
        drv_en <= 1'b0;
        step(1'b0);
        step(1'b0);
        step(1'b0);
        chk(press, 6'h28);
        drv_en <= 1'b1;
        pulse(10);
        chk(press, 6'h01);
        complete_run();
    end
endmodule // tb_eccentric_press_contact_monitor
`default_nettype wire
